// File: shared/prt_pkg.sv
// Package: register map, field positions and constants of the PWM auto-reload timer.
package prt_pkg;
    localparam int PRT_DW = 8;
    localparam int PRT_NPWM = 4;
    localparam int PRT_NCAP = 2;
    // Register addresses on the plain register port.
    localparam logic [7:0] PRT_DUTY3_OFS = 8'h73;
    localparam logic [7:0] PRT_DUTY0_OFS = 8'h76;
    localparam logic [7:0] PRT_WAVE_OFS = 8'h77;
    localparam logic [7:0] PRT_TCS_OFS = 8'h78;
    localparam logic [7:0] PRT_CNT_OFS = 8'h79;
    localparam logic [7:0] PRT_RELOAD_OFS = 8'h7a;
    localparam logic [7:0] PRT_CAPCS_OFS = 8'h7b;
    localparam logic [7:0] PRT_CAP1_OFS = 8'h7c;
    localparam logic [7:0] PRT_IRQ_STAT_OFS = 8'h7e;
    localparam logic [7:0] PRT_IRQ_MASK_OFS = 8'h7f;
    // Timer control/status fields.
    localparam int PRT_CC_LSB = 4;
    localparam int PRT_CC_W = 3;
    localparam int PRT_TCE_BIT = 3;
    localparam int PRT_FCRL_BIT = 2;
    localparam int PRT_OIE_BIT = 1;
    localparam int PRT_OVF_BIT = 0;
    // Wave control fields.
    localparam int PRT_OE_LSB = 4;
    localparam int PRT_OP_LSB = 0;
    // Capture control/status fields.
    localparam int PRT_CS_LSB = 4;
    localparam int PRT_CIE_LSB = 2;
    localparam int PRT_CF_LSB = 0;
    // Interrupt status and mask layout.
    localparam int PRT_IRQ_OVF_BIT = 0;
    localparam int PRT_IRQ_CAP_LSB = 1;
    localparam int PRT_IRQ_W = 3;
    localparam int PRT_PRESC_W = 7;
    localparam logic [7:0] PRT_RST8 = 8'h00;
    localparam logic [7:0] PRT_CNT_TOP = 8'hff;
    localparam logic [7:0] PRT_UNMAPPED = 8'h00;
endpackage : prt_pkg

// File: rtl/prt_timer.sv
// Module: 8-bit auto-reload timer with four PWM outputs, two input captures and interrupt logic.
`timescale 1ns/10ps
module prt_timer
    import prt_pkg::*;
#(
    parameter int N_PWM = PRT_NPWM,
    parameter int N_CAP = PRT_NCAP
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [PRT_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PRT_DW-1:0] reg_rdata,
    // Pins.
    output logic [PRT_NPWM-1:0] wave_out_pin,
    output logic [PRT_NPWM-1:0] wave_out_oe,
    input wire logic [PRT_NCAP-1:0] capture_in_pin,
    // Interrupt.
    output logic irq_out
);
    if (N_PWM != PRT_NPWM || N_CAP != PRT_NCAP) begin : g_chk
        $error("prt_timer: channel counts are fixed by the register layout");
    end

    logic [7:0] counter_access_reg;
    logic [7:0] cnt_next;
    logic [7:0] reload_value_reg;
    logic [7:0] wave_control_reg;
    logic [7:0] wave_next;
    logic [7:0] duty_compare_reg [PRT_NPWM];
    logic [7:0] compare_value_reg [PRT_NPWM];
    logic [7:0] cmp_next [PRT_NPWM];
    logic [PRT_CC_W-1:0] cc_reg;
    logic tce_reg;
    logic oie_reg;
    logic overflow_flag_reg;
    logic [PRT_NCAP-1:0] cs_reg;
    logic [PRT_NCAP-1:0] capture_irq_enable_reg;
    logic [PRT_NCAP-1:0] capture_flag_reg;
    logic [7:0] capture_value_reg [PRT_NCAP];
    logic [PRT_NCAP-1:0] cap_prev_reg;
    logic [PRT_NCAP-1:0] cap_evt;
    logic [PRT_NCAP-1:0] cap_rd;
    logic [PRT_IRQ_W-1:0] irq_stat_reg;
    logic [PRT_IRQ_W-1:0] irq_mask_reg;
    logic [PRT_IRQ_W-1:0] irq_gate;
    logic [PRT_PRESC_W-1:0] presc_reg;
    logic [PRT_PRESC_W-1:0] div_mask;
    logic [PRT_DW-1:0] rd_mux;
    logic tick;
    logic cnt_wr;
    logic force_reload;
    logic ovf_evt;
    logic tcs_rd;
    logic irq_reg;
    logic [PRT_DW-1:0] rdata_reg;
    logic [PRT_NPWM-1:0] pin_reg;
    logic [PRT_NPWM-1:0] oe_reg;

    assign reg_rdata = rdata_reg;
    assign wave_out_pin = pin_reg;
    assign wave_out_oe = oe_reg;
    assign irq_out = irq_reg;

    // Prescaler: the counter advances on a one-cycle enable every 2**cc clocks.
    assign div_mask = PRT_PRESC_W'((8'h01 << cc_reg) - 8'h01);
    assign tick = tce_reg && ((presc_reg & div_mask) == div_mask);
    assign cnt_wr = reg_wr && (reg_addr == PRT_CNT_OFS);
    assign force_reload = reg_wr && (reg_addr == PRT_TCS_OFS) && reg_wdata[PRT_FCRL_BIT];
    assign tcs_rd = reg_rd && (reg_addr == PRT_TCS_OFS);
    // A software write of the count wins over a wrap in the same cycle.
    assign ovf_evt = tick && (counter_access_reg == PRT_CNT_TOP) && !cnt_wr && !force_reload;

    always_ff @(posedge sys_clk) begin
        if (!rst_b || force_reload || !tce_reg) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    always_comb begin
        cnt_next = counter_access_reg;
        if (cnt_wr) begin
            cnt_next = reg_wdata;
        end else if (force_reload || ovf_evt) begin
            cnt_next = reload_value_reg;
        end else if (tick) begin
            cnt_next = counter_access_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            counter_access_reg <= PRT_RST8;
        end else begin
            counter_access_reg <= cnt_next;
        end
    end

    // Plain software registers.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reload_value_reg <= PRT_RST8;
            wave_control_reg <= PRT_RST8;
            cc_reg <= '0;
            tce_reg <= 1'b0;
            oie_reg <= 1'b0;
            cs_reg <= '0;
            capture_irq_enable_reg <= '0;
            irq_mask_reg <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                PRT_RELOAD_OFS: reload_value_reg <= reg_wdata;
                PRT_WAVE_OFS: wave_control_reg <= reg_wdata;
                PRT_TCS_OFS: begin
                    cc_reg <= reg_wdata[PRT_CC_LSB +: PRT_CC_W];
                    tce_reg <= reg_wdata[PRT_TCE_BIT];
                    oie_reg <= reg_wdata[PRT_OIE_BIT];
                end
                PRT_CAPCS_OFS: begin
                    cs_reg <= reg_wdata[PRT_CS_LSB +: PRT_NCAP];
                    capture_irq_enable_reg <= reg_wdata[PRT_CIE_LSB +: PRT_NCAP];
                end
                PRT_IRQ_MASK_OFS: irq_mask_reg <= reg_wdata[PRT_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Overflow flag: read of the control/status register clears it, a new overflow wins.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_evt) begin
            overflow_flag_reg <= 1'b1;
        end else if (tcs_rd) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    assign wave_next = (reg_wr && reg_addr == PRT_WAVE_OFS) ? reg_wdata : wave_control_reg;

    // PWM channels. Pins are computed from next-state values so that a polarity write,
    // a reload or a compare crossing shows on the pin in the very next cycle.
    for (genvar i = 0; i < PRT_NPWM; i++) begin : g_pwm
        // The compare shadow takes the duty value at each reload so a period is never torn.
        assign cmp_next[i] = (ovf_evt || force_reload) ? duty_compare_reg[i] : compare_value_reg[i];

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                duty_compare_reg[i] <= PRT_RST8;
            end else if (reg_wr && reg_addr == PRT_DUTY0_OFS - 8'(i)) begin
                duty_compare_reg[i] <= reg_wdata;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                compare_value_reg[i] <= PRT_RST8;
            end else begin
                compare_value_reg[i] <= cmp_next[i];
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                pin_reg[i] <= 1'b0;
                oe_reg[i] <= 1'b0;
            end else begin
                oe_reg[i] <= wave_next[PRT_OE_LSB + i];
                pin_reg[i] <= wave_next[PRT_OE_LSB + i] &&
                    ((cnt_next <= cmp_next[i]) ^ wave_next[PRT_OP_LSB + i]);
            end
        end

        pin_track_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            wave_control_reg[PRT_OE_LSB + i] |->
            wave_out_pin[i] == ((counter_access_reg <= compare_value_reg[i]) ^ wave_control_reg[PRT_OP_LSB + i]))
            else $error("PWM pin does not follow count, compare and polarity");
        ovf_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            ovf_evt && wave_control_reg[PRT_OE_LSB + i] && !reg_wr && duty_compare_reg[i] > reload_value_reg
            |=> wave_out_pin[i] == !$past(wave_control_reg[PRT_OP_LSB + i]))
            else $error("PWM pin not at start level after reload");
        oe_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            !wave_control_reg[PRT_OE_LSB + i] |-> !wave_out_pin[i] && !wave_out_oe[i])
            else $error("Disabled PWM channel still drives");
        pol_flip_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            $changed(wave_control_reg[PRT_OP_LSB + i]) && $stable(counter_access_reg) &&
            $stable(compare_value_reg[i]) && wave_control_reg[PRT_OE_LSB + i] && $past(wave_out_oe[i])
            |-> wave_out_pin[i] != $past(wave_out_pin[i]))
            else $error("Polarity change did not invert the pin at once");
    end

    // Capture channels; inputs are already synchronous to sys_clk.
    for (genvar c = 0; c < PRT_NCAP; c++) begin : g_cap
        logic edge_hit;
        assign edge_hit = cs_reg[c] ? (!cap_prev_reg[c] && capture_in_pin[c])
                                    : (cap_prev_reg[c] && !capture_in_pin[c]);
        // A pending capture blocks the next one so unread data is never overwritten.
        assign cap_evt[c] = edge_hit && !capture_flag_reg[c];
        assign cap_rd[c] = reg_rd && (reg_addr == PRT_CAP1_OFS + 8'(c));

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                cap_prev_reg[c] <= 1'b0;
            end else begin
                cap_prev_reg[c] <= capture_in_pin[c];
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                capture_value_reg[c] <= PRT_RST8;
            end else if (cap_evt[c]) begin
                capture_value_reg[c] <= counter_access_reg;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                capture_flag_reg[c] <= 1'b0;
            end else if (cap_evt[c]) begin
                capture_flag_reg[c] <= 1'b1;
            end else if (cap_rd[c]) begin
                capture_flag_reg[c] <= 1'b0;
            end
        end

        cap_take_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            cap_evt[c] |=> capture_value_reg[c] == $past(counter_access_reg) && capture_flag_reg[c])
            else $error("Capture did not latch the count");
        cap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            capture_flag_reg[c] |=> $stable(capture_value_reg[c]))
            else $error("Capture data changed while pending");
        cap_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            capture_flag_reg[c] && !cap_rd[c] |=> capture_flag_reg[c])
            else $error("Capture flag cleared without a data read");
        edge_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
            !capture_flag_reg[c] && cs_reg[c] && !cap_prev_reg[c] && capture_in_pin[c]
            |=> capture_flag_reg[c] ##1 capture_flag_reg[c] || $past(cap_rd[c]))
            else $error("Rising edge not captured");
    end

    // Sticky interrupt status, cleared by writing one; a new event wins over the clear.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_stat_reg <= '0;
        end else begin
            for (int b = 0; b < PRT_IRQ_W; b++) begin
                if (reg_wr && reg_addr == PRT_IRQ_STAT_OFS && reg_wdata[b]) begin
                    irq_stat_reg[b] <= 1'b0;
                end
            end
            if (ovf_evt) begin
                irq_stat_reg[PRT_IRQ_OVF_BIT] <= 1'b1;
            end
            for (int k = 0; k < PRT_NCAP; k++) begin
                if (cap_evt[k]) begin
                    irq_stat_reg[PRT_IRQ_CAP_LSB + k] <= 1'b1;
                end
            end
        end
    end

    assign irq_gate = {capture_irq_enable_reg, oie_reg};

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg & irq_gate);
        end
    end

    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (irq_stat_reg & irq_mask_reg & irq_gate) == '0 |=> !irq_out)
        else $error("Interrupt raised without an enabled source");

    // Read path; the answer stands only in the cycle after the strobe.
    always_comb begin
        rd_mux = PRT_UNMAPPED;
        case (reg_addr)
            PRT_CNT_OFS: rd_mux = counter_access_reg;
            PRT_RELOAD_OFS: rd_mux = reload_value_reg;
            PRT_WAVE_OFS: rd_mux = wave_control_reg;
            PRT_TCS_OFS: rd_mux = {1'b0, cc_reg, tce_reg, 1'b0, oie_reg, overflow_flag_reg};
            PRT_CAPCS_OFS: rd_mux = {2'h0, cs_reg, capture_irq_enable_reg, capture_flag_reg};
            PRT_CAP1_OFS: rd_mux = capture_value_reg[0];
            PRT_CAP1_OFS + 8'h01: rd_mux = capture_value_reg[1];
            PRT_IRQ_STAT_OFS: rd_mux = 8'(irq_stat_reg);
            PRT_IRQ_MASK_OFS: rd_mux = 8'(irq_mask_reg);
            default: begin
                if (reg_addr >= PRT_DUTY3_OFS && reg_addr <= PRT_DUTY0_OFS) begin
                    rd_mux = duty_compare_reg[2'(PRT_DUTY0_OFS - reg_addr)];
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata_reg <= PRT_RST8;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : PRT_RST8;
        end
    end

    cnt_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cnt_wr |=> counter_access_reg == $past(reg_wdata))
        else $error("Counter write not taken");
    reload_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ovf_evt |=> counter_access_reg == $past(reload_value_reg) && overflow_flag_reg)
        else $error("Overflow did not reload the counter or set the flag");
    resv_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd && reg_addr == PRT_CAPCS_OFS |=> reg_rdata[7:6] == 2'h0)
        else $error("Reserved capture bits read non-zero");

    ovf_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_b) ovf_evt);
    cap_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_b) cap_evt[0] ##[1:50] cap_rd[0]);
    irq_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(irq_out));
    pol_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_b) $changed(wave_control_reg[PRT_OP_LSB]));
endmodule : prt_timer

// File: dv/prt_timer_tb_top.sv
// Testbench: register-level checks of the PWM auto-reload timer with capture and interrupt.
`timescale 1ns/10ps
module prt_timer_tb_top;
    import prt_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] wave_out_pin;
    logic [3:0] wave_out_oe;
    logic [1:0] capture_in_pin = 2'b00;
    logic irq_out;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] v;
    logic [7:0] a;
    logic [3:0] p;
    logic [7:0] hi [4];
    logic [7:0] duty [4] = '{8'hf8, 8'hf0, 8'hff, 8'hef};

    always #5 sys_clk = ~sys_clk;

    prt_timer DUT (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .wave_out_pin(wave_out_pin),
        .wave_out_oe(wave_out_oe),
        .capture_in_pin(capture_in_pin),
        .irq_out(irq_out)
    );

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] ad, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(ad, d);
        chk(what, exp, d);
    endtask : rdc

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_clk

    // A window of one full period counts the high cycles whatever its phase.
    task automatic meas(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
        for (int i = 0; i < 4; i++) begin
            hi[i] = 8'h00;
        end
        repeat (16) begin
            @(posedge sys_clk);
            #1;
            for (int i = 0; i < 4; i++) begin
                hi[i] = hi[i] + {7'h00, wave_out_pin[i]};
            end
        end
        chk("high_cycles_ch0", e0, hi[0]);
        chk("high_cycles_ch1", e1, hi[1]);
        chk("high_cycles_ch2", e2, hi[2]);
        chk("high_cycles_ch3", e3, hi[3]);
    endtask : meas

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            $display("ERROR run_cycles expected below 20000 seen 20000");
            stop_test();
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int ad = 8'h73; ad <= 8'h7f; ad++) begin
            rdc(8'(ad), PRT_RST8, "reset_value");
        end
        rdc(8'h00, PRT_UNMAPPED, "unmapped_read");
        chk("oe_after_reset", 8'h00, {4'h0, wave_out_oe});
        wr(PRT_CNT_OFS, 8'h5a);
        rdc(PRT_CNT_OFS, 8'h5a, "count_write_read");
        // Captures while the counter is stopped, so the captured values are known.
        wr(PRT_CAPCS_OFS, 8'hdc);
        rdc(PRT_CAPCS_OFS, 8'h1c, "capcs_reserved");
        wr(PRT_CNT_OFS, 8'h42);
        @(posedge sys_clk);
        capture_in_pin <= 2'b11;
        wr(PRT_CNT_OFS, 8'h55);
        @(posedge sys_clk);
        capture_in_pin <= 2'b00;
        wr(PRT_CNT_OFS, 8'h66);
        @(posedge sys_clk);
        capture_in_pin <= 2'b11;
        wait_clk(2);
        rdc(PRT_CAPCS_OFS, 8'h1f, "capcs_flags");
        wr(PRT_IRQ_MASK_OFS, 8'h06);
        wait_clk(2);
        chk("irq_capture", 8'h01, {7'h00, irq_out});
        rdc(PRT_CAP1_OFS, 8'h42, "cap1_data");
        rdc(PRT_CAP1_OFS + 8'h01, 8'h55, "cap2_data");
        rdc(PRT_CAPCS_OFS, 8'h1c, "capcs_flags_cleared");
        wr(PRT_IRQ_STAT_OFS, 8'h06);
        wr(PRT_CAPCS_OFS, 8'h10);
        @(posedge sys_clk);
        capture_in_pin <= 2'b00;
        @(posedge sys_clk);
        capture_in_pin <= 2'b01;
        wait_clk(3);
        chk("irq_capture_disabled", 8'h00, {7'h00, irq_out});
        rdc(PRT_CAPCS_OFS, 8'h13, "capcs_flags_noirq");
        rdc(PRT_CAP1_OFS, 8'h66, "cap1_after_release");
        rdc(PRT_CAP1_OFS + 8'h01, 8'h66, "cap2_after_release");
        wr(PRT_IRQ_STAT_OFS, 8'h07);
        wr(PRT_IRQ_MASK_OFS, 8'h00);
        // PWM with a 16-count period.
        wr(PRT_RELOAD_OFS, 8'hf0);
        rdc(PRT_RELOAD_OFS, 8'hf0, "reload_rw");
        for (int i = 0; i < 4; i++) begin
            wr(PRT_DUTY0_OFS - 8'(i), duty[i]);
        end
        wr(PRT_WAVE_OFS, 8'hf0);
        wr(PRT_TCS_OFS, 8'h0c);
        wait_clk(4);
        meas(8'd9, 8'd1, 8'd16, 8'd0);
        chk("oe_all", 8'h0f, {4'h0, wave_out_oe});
        wr(PRT_WAVE_OFS, 8'hdd);
        wait_clk(2);
        meas(8'd7, 8'd0, 8'd0, 8'd16);
        chk("oe_partial", 8'h0d, {4'h0, wave_out_oe});
        wr(PRT_TCS_OFS, 8'h00);
        wait_clk(2);
        p = wave_out_pin;
        wr(PRT_WAVE_OFS, 8'hd8);
        wait_clk(1);
        chk("pins_after_polarity", {4'h0, p ^ 4'b0101}, {4'h0, wave_out_pin});
        // Running counter with full 8-bit period.
        wr(PRT_RELOAD_OFS, 8'h00);
        wr(PRT_TCS_OFS, 8'h08);
        wr(PRT_CNT_OFS, 8'h00);
        rd(PRT_CNT_OFS, a);
        chk("count_after_write", 8'h01, a);
        rd(PRT_CNT_OFS, v);
        chk("count_advance", 8'h02, v - a);
        rd(PRT_TCS_OFS, v);
        rdc(PRT_TCS_OFS, 8'h08, "ovf_cleared_by_read");
        wait_clk(260);
        rdc(PRT_TCS_OFS, 8'h09, "ovf_set_on_wrap");
        // Overflow interrupt: raised, masked, cleared.
        wr(PRT_IRQ_STAT_OFS, 8'h07);
        wr(PRT_TCS_OFS, 8'h0a);
        wr(PRT_IRQ_MASK_OFS, 8'h01);
        wait_clk(260);
        chk("irq_overflow", 8'h01, {7'h00, irq_out});
        rdc(PRT_IRQ_STAT_OFS, 8'h01, "irq_status");
        wr(PRT_IRQ_MASK_OFS, 8'h00);
        wait_clk(2);
        chk("irq_masked", 8'h00, {7'h00, irq_out});
        wr(PRT_TCS_OFS, 8'h02);
        wr(PRT_IRQ_MASK_OFS, 8'h01);
        wait_clk(2);
        chk("irq_unmasked", 8'h01, {7'h00, irq_out});
        wr(PRT_IRQ_STAT_OFS, 8'h01);
        wait_clk(2);
        chk("irq_cleared", 8'h00, {7'h00, irq_out});
        // Divide by two: reads two cycles apart must see exactly one step of the count.
        wr(PRT_TCS_OFS, 8'h18);
        rd(PRT_CNT_OFS, a);
        rd(PRT_CNT_OFS, v);
        chk("count_prescaled", 8'h01, v - a);
        stop_test();
    end
endmodule : prt_timer_tb_top
